// ---- rtl/pvh_proc.sv ----
// peak and valley hold post-processing of object temperature samples
`timescale 1ns/1ps
module pvh_proc #(
    parameter int TICK_CYCLES = pvh_pkg::TICK_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire pvh_pkg::pvh_bus_t bus_i,
    output logic [pvh_pkg::DATA_W-1:0] rdata_o,
    input wire logic sample_valid_i,
    input wire logic [pvh_pkg::TEMP_W-1:0] sample_i,
    output logic sample_ready_o,
    output logic result_valid_o,
    output logic [pvh_pkg::TEMP_W-1:0] result_o,
    input wire logic result_ready_i,
    input wire logic ext_restart_n_i,
    input wire logic panel_wr_i,
    input wire pvh_pkg::pvh_panel_t panel_i,
    output logic panel_reject_o
);
    import pvh_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    function automatic logic is_adv(input pvh_mode_t m);
        return m inside {MODE_APEAK, MODE_AVALLEY, MODE_APEAK_AVG, MODE_AVALLEY_AVG};
    endfunction

    function automatic logic is_inv(input pvh_mode_t m);
        return m inside {MODE_AVALLEY, MODE_AVALLEY_AVG};
    endfunction

    // advanced valley variants run the peak search on negated values
    function automatic logic signed [TEMP_W:0] orient(input logic signed [TEMP_W-1:0] v, input logic inv);
        logic signed [TEMP_W:0] e;
        e = {v[TEMP_W-1], v};
        return inv ? -e : e;
    endfunction

    function automatic logic [TEMP_W-1:0] hold_out(input pvh_mode_t m, input logic [TEMP_W-1:0] vh,
                                                   input logic signed [TEMP_W:0] pk);
        logic signed [TEMP_W:0] back;
        back = is_inv(m) ? -pk : pk;
        return (m == MODE_VALLEY) ? vh : back[TEMP_W-1:0];
    endfunction

    // shift k with exp(-n/2^k) near 0.1 after n ticks: 23 * 2^k <= 10 * n
    function automatic logic [4:0] avg_shift(input logic [TEMP_W-1:0] n);
        logic [4:0] k;
        k = 5'h00;
        for (int i = 1; i < 16; i++) begin
            if ((32'h17 << i) <= 32'(n) * 32'hA) begin
                k = 5'(i);
            end
        end
        return k;
    endfunction

    // ****************************************
    // state
    // ****************************************
    pvh_cfg_t cfg, next_cfg;
    logic [DATA_W-1:0] next_rdata;
    logic next_panel_reject;
    logic [TW-1:0] tick_cnt, next_tick_cnt;
    logic tick, next_tick;
    logic rs_meta, rs_sync;
    pvh_vh_state_t vh_state, next_vh_state;
    logic signed [TEMP_W-1:0] vh_held, next_vh_held;
    logic [HOLD_W-1:0] vh_timer, next_vh_timer;
    logic signed [TEMP_W:0] pk_held, next_pk_held, pk_cand, next_pk_cand;
    logic pk_armed, next_pk_armed;
    logic reseed, next_reseed;
    logic signed [DATA_W-1:0] acc, next_acc;
    logic [TEMP_W-1:0] next_result;
    logic next_result_valid;

    logic f_valid, f_ready, take;
    logic [TEMP_W-1:0] f_data;
    logic signed [TEMP_W:0] x, thr, cmax;
    logic signed [TEMP_W+1:0] drop;
    logic found;
    logic signed [DATA_W:0] diff;
    logic [TEMP_W-1:0] hv_now;
    logic [4:0] k;

    pvh_fifo #(.WIDTH(TEMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(sample_valid_i),
        .in_data_i(sample_i),
        .in_ready_o(sample_ready_o),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .out_ready_i(f_ready)
    );

    assign f_ready = !result_valid_o || result_ready_i;
    assign take = f_valid && f_ready;

    // ****************************************
    // register port and local panel
    // ****************************************
    always_comb begin
        next_cfg = cfg;
        next_rdata = '0;
        next_panel_reject = 1'b0;
        if (bus_i.wr) begin
            case (bus_i.addr)
                OFS_MODE: next_cfg.mode = pvh_mode_t'(bus_i.wdata[2:0]);
                OFS_HOLD: begin
                    if (bus_i.wdata[HOLD_W-1:0] < HOLD_MIN) begin
                        next_cfg.hold = HOLD_MIN;
                    end else if (bus_i.wdata[HOLD_W-1:0] > HOLD_CONT || bus_i.wdata[DATA_W-1:HOLD_W] != '0) begin
                        next_cfg.hold = HOLD_CONT;
                    end else begin
                        next_cfg.hold = bus_i.wdata[HOLD_W-1:0];
                    end
                end
                OFS_THRESH: next_cfg.thresh = bus_i.wdata[TEMP_W-1:0];
                OFS_HYST: next_cfg.hyst = bus_i.wdata[TEMP_W-1:0];
                OFS_AVG: next_cfg.avg = bus_i.wdata[TEMP_W-1:0];
                default: next_cfg = cfg;
            endcase
        end else if (panel_wr_i) begin
            // panel may only touch basic modes; host writes take priority
            if (is_adv(panel_i.mode) || is_adv(cfg.mode)) begin
                next_panel_reject = 1'b1;
            end else begin
                next_cfg.mode = panel_i.mode;
                next_cfg.hold = (panel_i.hold > HOLD_CONT) ? HOLD_CONT :
                                (panel_i.hold < HOLD_MIN) ? HOLD_MIN : panel_i.hold;
            end
        end
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFS_MODE: next_rdata = DATA_W'(cfg.mode);
                OFS_HOLD: next_rdata = DATA_W'(cfg.hold);
                OFS_THRESH: next_rdata = DATA_W'(cfg.thresh);
                OFS_HYST: next_rdata = DATA_W'(cfg.hyst);
                OFS_AVG: next_rdata = DATA_W'(cfg.avg);
                OFS_STATUS: begin
                    next_rdata[STAT_HOLDING_BIT] = (vh_state == VH_HOLD);
                    next_rdata[STAT_ARMED_BIT] = pk_armed;
                    next_rdata[STAT_RESTART_BIT] = !rs_sync;
                    next_rdata[STAT_RESULT_BIT] = result_valid_o;
                end
                OFS_OUTPUT: next_rdata = DATA_W'(result_o);
                default: next_rdata = '0;
            endcase
        end
    end

    // ****************************************
    // tenth-second tick
    // ****************************************
    always_comb begin
        next_tick = (tick_cnt == TW'(TICK_CYCLES - 1));
        next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
    end

    // ****************************************
    // hold and averaging engine
    // ****************************************
    always_comb begin
        x = orient(f_data, is_inv(cfg.mode));
        thr = orient(cfg.thresh, is_inv(cfg.mode));
        cmax = (x > pk_cand) ? x : pk_cand;
        drop = {cmax[TEMP_W], cmax} - {x[TEMP_W], x};
        found = pk_armed && (drop >= $signed({2'b00, cfg.hyst}));
        hv_now = hold_out(cfg.mode, vh_held, pk_held);
        k = avg_shift(cfg.avg);
        diff = {hv_now[TEMP_W-1], hv_now, 16'h0000} - {acc[DATA_W-1], acc};
        next_vh_state = vh_state;
        next_vh_held = vh_held;
        next_vh_timer = vh_timer;
        next_pk_held = pk_held;
        next_pk_cand = pk_cand;
        next_pk_armed = pk_armed;
        next_reseed = reseed;
        next_acc = acc;
        next_result = result_o;
        next_result_valid = result_valid_o && !result_ready_i;
        // basic valley timer, 999 s never expires
        if (vh_state == VH_HOLD && tick && cfg.hold != HOLD_CONT) begin
            if (vh_timer + 1'b1 >= cfg.hold) begin
                next_vh_state = VH_TRACK;
                next_vh_timer = '0;
                // forget the old minimum so the next sample is tracked, not compared
                next_vh_held = 16'sh7FFF;
            end else begin
                next_vh_timer = vh_timer + 1'b1;
            end
        end
        if (tick && (cfg.mode == MODE_APEAK_AVG || cfg.mode == MODE_AVALLEY_AVG)) begin
            next_acc = acc + DATA_W'(diff >>> k);
        end
        if (take) begin
            next_reseed = 1'b0;
            if (reseed) begin
                next_vh_state = VH_TRACK;
                next_vh_timer = '0;
                next_vh_held = f_data;
                next_pk_held = x;
                next_pk_cand = x;
                next_pk_armed = 1'b1;
            end else begin
                if (next_vh_state == VH_TRACK) begin
                    if ($signed(f_data) > vh_held) begin
                        next_vh_state = VH_HOLD;
                        next_vh_timer = '0;
                    end else begin
                        next_vh_held = f_data;
                    end
                end else if ($signed(f_data) < vh_held) begin
                    next_vh_held = f_data;
                    next_vh_timer = '0;
                end
                next_pk_cand = cmax;
                if (x > pk_held) begin
                    next_pk_held = x;
                end
                if (found) begin
                    if (x < thr) begin
                        next_pk_held = cmax;
                    end
                    next_pk_armed = 1'b0;
                    next_pk_cand = x;
                end else if (!pk_armed && x < thr) begin
                    next_pk_armed = 1'b1;
                    next_pk_cand = x;
                end
            end
            if (reseed && (cfg.mode == MODE_APEAK_AVG || cfg.mode == MODE_AVALLEY_AVG)) begin
                next_acc = {f_data, 16'h0000};
            end
            case (cfg.mode)
                MODE_TRACK: next_result = f_data;
                MODE_APEAK_AVG, MODE_AVALLEY_AVG: next_result = reseed ? f_data : acc[DATA_W-1:ACC_FRAC];
                default: next_result = hold_out(cfg.mode, next_vh_held, next_pk_held);
            endcase
            next_result_valid = 1'b1;
        end
        // a mode write beats a sample taken in the same cycle
        if (bus_i.wr && bus_i.addr == OFS_MODE) begin
            next_reseed = 1'b1;
        end
        // restart input aborts the hold immediately; next sample reseeds
        if (!rs_sync) begin
            next_vh_state = VH_TRACK;
            next_vh_timer = '0;
            next_reseed = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cfg <= '{MODE_TRACK, RST_HOLD, RST_THRESH, RST_HYST, RST_AVG};
            rdata_o <= '0;
            panel_reject_o <= 1'b0;
            tick_cnt <= '0;
            tick <= 1'b0;
            rs_meta <= 1'b1;
            rs_sync <= 1'b1;
            vh_state <= VH_TRACK;
            vh_held <= '0;
            vh_timer <= '0;
            pk_held <= '0;
            pk_cand <= '0;
            pk_armed <= 1'b0;
            reseed <= 1'b1;
            acc <= '0;
            result_o <= '0;
            result_valid_o <= 1'b0;
        end else begin
            cfg <= next_cfg;
            rdata_o <= next_rdata;
            panel_reject_o <= next_panel_reject;
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            rs_meta <= ext_restart_n_i;
            rs_sync <= rs_meta;
            vh_state <= next_vh_state;
            vh_held <= next_vh_held;
            vh_timer <= next_vh_timer;
            pk_held <= next_pk_held;
            pk_cand <= next_pk_cand;
            pk_armed <= next_pk_armed;
            reseed <= next_reseed;
            acc <= next_acc;
            result_o <= next_result;
            result_valid_o <= next_result_valid;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic adv_take;
    assign adv_take = take && is_adv(cfg.mode) && !reseed;

    cont_no_expire_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        vh_state == VH_HOLD && cfg.hold == HOLD_CONT && rs_sync && !reseed |=> vh_state == VH_HOLD)
        else $error("continuous valley hold expired");
    restart_abort_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !rs_sync |=> vh_state == VH_TRACK && vh_timer == '0 && reseed)
        else $error("restart did not abort the hold");
    peak_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        adv_take |=> pk_held >= $past(x))
        else $error("held value below a newer higher sample");
    rearm_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        adv_take && !pk_armed && x >= thr |=> !pk_armed)
        else $error("search restarted above threshold");
    hyst_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        adv_take && pk_armed && drop < $signed({2'b00, cfg.hyst}) |=> pk_armed && pk_cand == $past(cmax))
        else $error("maximum accepted inside hysteresis");
    step_down_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        adv_take && found && x < thr ##1 !take |=> pk_held == $past(cmax, 2))
        else $error("output did not step to the found maximum");
    timer_expire_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        vh_state == VH_HOLD && tick && cfg.hold != HOLD_CONT && vh_timer + 1'b1 >= cfg.hold
        && !take && rs_sync |=> vh_state == VH_TRACK)
        else $error("valley hold outlived the hold time");
    panel_lock_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        panel_wr_i && !bus_i.wr && is_adv(panel_i.mode) |=> panel_reject_o && cfg.mode == $past(cfg.mode))
        else $error("panel changed an advanced mode");
    reset_clear_a: assert property (@(posedge mclk_i)
        $rose(rst_n_i) |-> vh_state == VH_TRACK && vh_timer == '0 && reseed && !result_valid_o)
        else $error("reset left hold state behind");
endmodule

// ---- rtl/pvh_pkg.sv ----
// constants, types and register map of the peak and valley hold processor
// How it works
// - valley hold time of 999 s selects continuous detection, no timer expiry.
// - low restart input aborts the hold and restarts minimum detection at once.
// - advanced peak hold shows a found local maximum until a newer one appears.
// - a new local maximum search starts only after temperature drops below threshold.
// - temperature above the held value makes the output follow it directly.
// - maximum found while below threshold makes the output step to that maximum.
// - a maximum counts only after the temperature falls back by the hysteresis.
// - advanced valley hold is the mirror image of advanced peak hold.
// - advanced peak hold with averaging smooths the peak output by the average time.
// - advanced valley hold with averaging smooths the valley output the same way.
// - advanced modes and parameters are set only by the host port, not the panel.
// - basic valley hold tracks, holds the minimum 0.1 to 998.9 s, then tracks again.
// - averaging reaches 90 percent of a step after the average time.
package pvh_pkg;
    // ****************************************
    // widths and register map
    // ****************************************
    localparam int TEMP_W = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int HOLD_W = 14;
    localparam int ACC_FRAC = 16;
    localparam int FIFO_DEPTH = 32;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_HOLD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_HYST = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_AVG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h18;
    localparam int STAT_HOLDING_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_RESTART_BIT = 2;
    localparam int STAT_RESULT_BIT = 3;
    // ****************************************
    // reset values and hold time limits, in tenths of a second
    // ****************************************
    localparam logic [HOLD_W-1:0] RST_HOLD = 14'h0064;
    localparam logic [TEMP_W-1:0] RST_THRESH = 16'h0000;
    localparam logic [TEMP_W-1:0] RST_HYST = 16'h000A;
    localparam logic [TEMP_W-1:0] RST_AVG = 16'h0000;
    localparam logic [HOLD_W-1:0] HOLD_MIN = 14'h0001;
    localparam logic [HOLD_W-1:0] HOLD_CONT = 14'h2706;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 100000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        MODE_TRACK, MODE_VALLEY, MODE_APEAK, MODE_AVALLEY, MODE_APEAK_AVG, MODE_AVALLEY_AVG
    } pvh_mode_t;
    typedef enum logic {VH_TRACK, VH_HOLD} pvh_vh_state_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pvh_bus_t;
    typedef struct packed {
        pvh_mode_t mode;
        logic [HOLD_W-1:0] hold;
    } pvh_panel_t;
    typedef struct packed {
        pvh_mode_t mode;
        logic [HOLD_W-1:0] hold;
        logic signed [TEMP_W-1:0] thresh;
        logic [TEMP_W-1:0] hyst;
        logic [TEMP_W-1:0] avg;
    } pvh_cfg_t;
endpackage

// ---- rtl/pvh_fifo.sv ----
// sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module pvh_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, next_wp, rp, next_rp;
    logic [AW:0] count, next_count;
    logic next_in_ready;
    logic push, pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rp];

    always_comb begin
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        // registered so the source sees a flop, not the pointer arithmetic
        next_in_ready = (next_count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
            in_ready_o <= 1'b0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            count <= next_count;
            in_ready_o <= next_in_ready;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end
endmodule

// ---- test/pvh_sample_src.sv ----
// sample source model standing in for the sensing head
`timescale 1ns/1ps
module pvh_sample_src (
    input wire logic mclk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [pvh_pkg::TEMP_W-1:0] data_o
);
    initial begin
        valid_o = 1'b0;
        data_o = 16'h0000;
    end
    // a sample is held until taken; gap idles the source to model a slow head
    task automatic push(input logic [15:0] v, input int gap);
        repeat (gap + 1) @(posedge mclk_i);
        valid_o <= 1'b1;
        data_o <= v;
        @(posedge mclk_i);
        while (ready_i !== 1'b1) @(posedge mclk_i);
        valid_o <= 1'b0;
        // released data shows the inverse so a stale value never passes for a sample
        data_o <= ~v;
    endtask
endmodule

// ---- test/tb_peak_valley_hold_processor.sv ----
// self-checking bench of the peak and valley hold processor
`timescale 1ns/1ps
module tb_peak_valley_hold_processor;
    import pvh_pkg::*;
    typedef struct {logic [2:0] mode; logic [15:0] smp; logic [15:0] exp; int wt;} pvh_row_t;
    logic mclk_i, rst_n_i, sample_valid_i, sample_ready_o, result_valid_o, result_ready_i;
    logic ext_restart_n_i, panel_wr_i, panel_reject_o;
    logic [15:0] sample_i, result_o, v;
    logic [31:0] rdata_o;
    logic [2:0] cur;
    pvh_bus_t bus;
    pvh_panel_t panel_i;
    logic [15:0] res_q [$];
    int fail_count, compares, n;
    logic [7:0] ra [6] = '{OFS_MODE, OFS_HOLD, OFS_THRESH, OFS_HYST, OFS_AVG, 8'h20};
    logic [31:0] rv [6] = '{32'h0, 32'h64, 32'h0, 32'hA, 32'h0, 32'h0};
    pvh_row_t rows [] = '{
        '{3'h0, 16'h0005, 16'h0005, 0}, '{3'h0, 16'hFFF0, 16'hFFF0, 3},
        '{3'h2, 16'h0014, 16'h0014, 0}, '{3'h2, 16'h001E, 16'h001E, 0}, '{3'h2, 16'h003C, 16'h003C, 0},
        '{3'h2, 16'h002D, 16'h003C, 0}, '{3'h2, 16'h0028, 16'h003C, 0}, '{3'h2, 16'h0037, 16'h003C, 2},
        '{3'h2, 16'h0046, 16'h0046, 0}, '{3'h2, 16'h0014, 16'h0046, 0}, '{3'h2, 16'h0028, 16'h0046, 0},
        '{3'h2, 16'h0023, 16'h0046, 0}, '{3'h2, 16'h0019, 16'h0028, 0},
        '{3'h3, 16'h0050, 16'h0050, 0}, '{3'h3, 16'h0046, 16'h0046, 0}, '{3'h3, 16'h0028, 16'h0028, 0},
        '{3'h3, 16'h0037, 16'h0028, 0}, '{3'h3, 16'h003C, 16'h0028, 0}, '{3'h3, 16'h001E, 16'h001E, 0},
        '{3'h3, 16'h0050, 16'h001E, 0}, '{3'h3, 16'h003C, 16'h001E, 0}, '{3'h3, 16'h0041, 16'h001E, 0},
        '{3'h3, 16'h004B, 16'h003C, 0},
        '{3'h1, 16'h0032, 16'h0032, 0}, '{3'h1, 16'h0028, 16'h0028, 0}, '{3'h1, 16'h002D, 16'h0028, 0},
        '{3'h1, 16'h003C, 16'h003C, 60}};

    pvh_proc #(.TICK_CYCLES(10)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sample_ready_o(sample_ready_o),
        .result_valid_o(result_valid_o), .result_o(result_o), .result_ready_i(result_ready_i),
        .ext_restart_n_i(ext_restart_n_i), .panel_wr_i(panel_wr_i), .panel_i(panel_i),
        .panel_reject_o(panel_reject_o));
    pvh_sample_src src_u (.mclk_i(mclk_i), .ready_i(sample_ready_o), .valid_o(sample_valid_i),
        .data_o(sample_i));

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        compares++;
        if (got !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, e, got);
        end
    endtask
    task automatic chk_rng(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fail_count++;
            $display("unexpected %s: expected %h to %h seen %h", what, lo, hi, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        bus <= '0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        bus <= '0;
        #1 chk("register", e, rdata_o);
    endtask
    task automatic panel(input logic [2:0] m, input logic e);
        @(posedge mclk_i);
        panel_wr_i <= 1'b1;
        panel_i <= '{mode: pvh_mode_t'(m), hold: 14'h0005};
        @(posedge mclk_i);
        panel_wr_i <= 1'b0;
        #1 chk("panel reject", {31'h0, e}, {31'h0, panel_reject_o});
    endtask
    task automatic get_res(output logic [15:0] r);
        int k;
        k = 0;
        while (res_q.size() == 0 && k < 200) begin
            @(posedge mclk_i);
            k++;
        end
        if (res_q.size() == 0) begin
            fail_count++;
            $display("unexpected result count: expected 1 seen 0");
            r = 'x;
        end else begin
            r = res_q.pop_front();
        end
    endtask
    task automatic run(input logic [15:0] s, input logic [15:0] e, input int wt);
        src_u.push(s, wt);
        get_res(v);
        chk("result", {16'h0, e}, {16'h0, v});
    endtask
    // the first result of a reseed passes straight through, the next stays at the old level; the one after a 300-cycle gap must settle near the new level
    task automatic avg_case(input logic [2:0] m, input logic [15:0] a, input logic [15:0] b,
                            input logic [15:0] lo, input logic [15:0] hi);
        wr_reg(OFS_MODE, {29'h0, m});
        run(a, a, 0);
        run(b, a, 0);
        src_u.push(b, 300);
        get_res(v);
        chk_rng("averaged result", {16'h0, lo}, {16'h0, hi}, {16'h0, v});
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        if (result_valid_o === 1'b1 && result_ready_i === 1'b1) begin
            res_q.push_back(result_o);
        end
    end
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (30000) @(posedge mclk_i);
        fail_count++;
        tally_and_finish();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst_n_i = 1'b0;
        bus = '0;
        result_ready_i = 1'b1;
        ext_restart_n_i = 1'b1;
        panel_wr_i = 1'b0;
        panel_i = '0;
        cur = 3'h7;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        foreach (ra[i]) rd_chk(ra[i], rv[i]);
        panel(3'h1, 1'b0);
        rd_chk(OFS_HOLD, 32'h5);
        panel(3'h2, 1'b1);
        wr_reg(OFS_MODE, 32'h2);
        panel(3'h1, 1'b1);
        wr_reg(8'h20, 32'hFF);
        rd_chk(OFS_MODE, 32'h2);
        wr_reg(OFS_THRESH, 32'h32);
        wr_reg(OFS_HOLD, 32'h2);
        foreach (rows[i]) begin
            if (rows[i].mode !== cur) begin
                wr_reg(OFS_MODE, {29'h0, rows[i].mode});
                cur = rows[i].mode;
            end
            run(rows[i].smp, rows[i].exp, rows[i].wt);
        end
        wr_reg(OFS_HOLD, 32'h0);
        rd_chk(OFS_HOLD, 32'h1);
        wr_reg(OFS_HOLD, 32'hFFFF);
        rd_chk(OFS_HOLD, 32'h2706);
        wr_reg(OFS_MODE, 32'h1);
        run(16'h0032, 16'h0032, 0);
        run(16'h0028, 16'h0028, 0);
        run(16'h002D, 16'h0028, 0);
        run(16'h003C, 16'h0028, 100);
        rd_chk(OFS_OUTPUT, 32'h28);
        rd_chk(OFS_STATUS, 32'h3);
        @(posedge mclk_i);
        ext_restart_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rd_chk(OFS_STATUS, 32'h6);
        @(posedge mclk_i);
        ext_restart_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        run(16'h003C, 16'h003C, 0);
        wr_reg(OFS_AVG, 32'h5);
        avg_case(3'h4, 16'h0064, 16'h00C8, 16'h00BE, 16'h00C8);
        avg_case(3'h5, 16'h00C8, 16'h0064, 16'h0064, 16'h006E);
        wr_reg(OFS_MODE, 32'h0);
        result_ready_i <= 1'b0;
        n = 0;
        while (n < 40 && sample_ready_o === 1'b1) begin
            src_u.push(n[15:0], 0);
            n++;
            repeat (2) @(posedge mclk_i);
        end
        chk_rng("accepted samples", 32'd32, 32'd34, n);
        result_ready_i <= 1'b1;
        for (int i = 0; i < n; i++) begin
            get_res(v);
            chk("drained result", i, {16'h0, v});
        end
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1 chk("result after reset", 32'h0, {16'h0, result_o});
        rd_chk(OFS_AVG, 32'h0);
        tally_and_finish();
    end
endmodule
